// file: design/hbs_sequencer.sv
// Holding brake sequencer: enables, three timers, setpoint gate, brake outputs.
// Assumes all inputs synchronous to sys_clk; registers on a plain strobe port.
//
// Design decisions made here: the register addresses and the strobed register port.
`default_nettype none
`include "hbs_map.svh"
module hbs_sequencer (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Register port.
    input  wire logic [3:0]  regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [15:0]      regRdData,
    // Enable conditions.
    input  wire logic        ctrlEnableExt,
    input  wire logic        ctrlEnableInt,
    input  wire logic        pulseEnableExt,
    input  wire logic        pulseEnableInt,
    // Speed path.
    input  wire logic [15:0] speedSetpoint,
    input  wire logic [15:0] actualSpeed,
    output logic [15:0]      speedSetpointOut,
    output logic             speedLoopActive,
    output logic             motorDriveEnable,
    // Brake signals.
    output logic             openBrakeInternal,
    output logic             openBrakeStatusBit,
    output logic [3:0]       outputTerminal,
    output logic             ctrlEnableStatus
);
    localparam int TERMS = 4;

    typedef struct packed {
        hbs_pkg::hbs_state_t state;
        logic [15:0]         tickCnt;
        logic                tick;
        logic                seqEnable;
        logic                posMode;
        logic [15:0]         openTime;
        logic [15:0]         closeSpeed;
        logic [15:0]         delayTime;
        logic [15:0]         inhibitTime;
        logic [31:0]         funcSel;
        logic [3:0]          invSel;
        logic                ctrlEnPrev;
        logic                openBrake;
        logic                brakeOut;
        logic [3:0]          terms;
        logic [15:0]         setOut;
        logic                loopOn;
        logic                driveOn;
        logic                statusEn;
        logic [15:0]         rdData;
    } hbs_regs_t;

    hbs_regs_t st;
    hbs_regs_t next_st;

    logic ctrlEnable;
    logic pulseEnable;
    logic openExpired;
    logic delayExpired;
    logic inhibitExpired;
    logic loadOpen;
    logic loadDelay;
    logic loadInhibit;
    logic atCloseSpeed;
    logic [15:0] absSpeed;

    // Effective enables are the AND of the external and internal conditions; the controller enable also needs the pulse enable.
    assign ctrlEnable  = ctrlEnableExt & ctrlEnableInt & pulseEnable;
    assign pulseEnable = pulseEnableExt & pulseEnableInt;

    // Speed is signed; compare its magnitude with the close threshold.
    assign absSpeed     = actualSpeed[15] ? 16'(-actualSpeed) : actualSpeed;
    assign atCloseSpeed = (absSpeed <= st.closeSpeed);

    // Timer start conditions, each a one-cycle load.
    assign loadOpen    = ctrlEnable && !st.ctrlEnPrev;
    assign loadDelay   = !ctrlEnable && st.ctrlEnPrev && pulseEnable;
    assign loadInhibit = loadDelay;

    hbs_timer u_open (
        .sys_clk (sys_clk),
        .rst     (rst),
        .load    (loadOpen),
        .tick    (st.tick),
        .preset  (st.openTime),
        .expired (openExpired)
    );

    hbs_timer u_delay (
        .sys_clk (sys_clk),
        .rst     (rst),
        .load    (loadDelay),
        .tick    (st.tick),
        .preset  (st.delayTime),
        .expired (delayExpired)
    );

    hbs_timer u_inhibit (
        .sys_clk (sys_clk),
        .rst     (rst),
        .load    (loadInhibit),
        .tick    (st.tick),
        .preset  (st.inhibitTime),
        .expired (inhibitExpired)
    );

    // All next-state logic: tick divider, registers, sequencer and outputs.
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        next_st.ctrlEnPrev = ctrlEnable;

        // Control-cycle tick from the system clock.
        if (st.tickCnt >= 16'(`HBS_TICK_CYC - 1)) begin
            next_st.tickCnt = 16'h0000;
            next_st.tick    = 1'b1;
        end else begin
            next_st.tickCnt = st.tickCnt + 16'h0001;
        end

        // Register writes.
        if (regWr) begin
            case (regAddr)
                `HBS_ADDR_CTRL: begin
                    next_st.seqEnable = regWrData[`HBS_CTRL_SEQ_EN];
                    next_st.posMode   = regWrData[`HBS_CTRL_POS_MODE];
                end
                `HBS_ADDR_OPEN_T:    next_st.openTime    = regWrData;
                `HBS_ADDR_CLOSE_SPD: next_st.closeSpeed  = regWrData;
                `HBS_ADDR_DELAY_T:   next_st.delayTime   = regWrData;
                `HBS_ADDR_INHIB_T:   next_st.inhibitTime = regWrData;
                `HBS_ADDR_FUNC_SEL:  next_st.funcSel     = {st.funcSel[23:0], regWrData[7:0]};
                `HBS_ADDR_INV_SEL:   next_st.invSel      = regWrData[3:0];
                default: ;
            endcase
        end

        // Register reads: data stand only in the following cycle.
        next_st.rdData = 16'h0000;
        if (regRd) begin
            case (regAddr)
                `HBS_ADDR_CTRL:      next_st.rdData = {14'h0000, st.posMode, st.seqEnable};
                `HBS_ADDR_OPEN_T:    next_st.rdData = st.openTime;
                `HBS_ADDR_CLOSE_SPD: next_st.rdData = st.closeSpeed;
                `HBS_ADDR_DELAY_T:   next_st.rdData = st.delayTime;
                `HBS_ADDR_INHIB_T:   next_st.rdData = st.inhibitTime;
                `HBS_ADDR_FUNC_SEL:  next_st.rdData = {8'h00, st.funcSel[7:0]};
                `HBS_ADDR_INV_SEL:   next_st.rdData = {12'h000, st.invSel};
                `HBS_ADDR_STATUS:    next_st.rdData = {9'h000, st.state, st.statusEn,
                                                       st.openBrake, st.loopOn, st.driveOn};
                `HBS_ADDR_SETPOINT:  next_st.rdData = st.setOut;
                default:             next_st.rdData = 16'h0000;
            endcase
        end

        // Sequencer.
        case (st.state)
            hbs_pkg::HBS_IDLE: begin
                if (loadOpen) begin
                    next_st.state = hbs_pkg::HBS_OPENING;
                end
            end
            hbs_pkg::HBS_OPENING: begin
                if (!pulseEnable) begin
                    next_st.state = hbs_pkg::HBS_IDLE;
                end else if (loadDelay) begin
                    next_st.state = hbs_pkg::HBS_CLOSING;
                end else if (openExpired && !loadOpen) begin
                    next_st.state = hbs_pkg::HBS_RUN;
                end
            end
            hbs_pkg::HBS_RUN: begin
                if (!pulseEnable) begin
                    next_st.state = hbs_pkg::HBS_IDLE;
                end else if (loadDelay) begin
                    next_st.state = hbs_pkg::HBS_CLOSING;
                end
            end
            hbs_pkg::HBS_CLOSING, hbs_pkg::HBS_INHIBIT: begin
                if (!pulseEnable) begin
                    next_st.state = hbs_pkg::HBS_IDLE;
                end else if (loadOpen) begin
                    next_st.state = hbs_pkg::HBS_OPENING;
                end else if (inhibitExpired && !loadDelay) begin
                    next_st.state = hbs_pkg::HBS_IDLE;
                end else begin
                    next_st.state = hbs_pkg::HBS_INHIBIT;
                end
            end
            default: next_st.state = hbs_pkg::HBS_IDLE;
        endcase

        // Brake open from enable until either close condition.
        // Setpoint is forced to zero the moment enable drops, so the
        // inhibit timer starts at the same edge as the delay timer.
        case (next_st.state)
            hbs_pkg::HBS_OPENING: next_st.openBrake = 1'b1;
            hbs_pkg::HBS_RUN:     next_st.openBrake = 1'b1;
            hbs_pkg::HBS_CLOSING, hbs_pkg::HBS_INHIBIT: begin
                if (st.state == hbs_pkg::HBS_OPENING || st.state == hbs_pkg::HBS_RUN) begin
                    next_st.openBrake = 1'b1;
                end
                if (atCloseSpeed) begin
                    next_st.openBrake = 1'b0;
                end
                if (delayExpired && !loadDelay) begin
                    next_st.openBrake = 1'b0;
                end
            end
            default: next_st.openBrake = 1'b0;
        endcase

        next_st.loopOn   = (next_st.state != hbs_pkg::HBS_IDLE);
        next_st.driveOn  = next_st.loopOn;
        next_st.statusEn = (next_st.state == hbs_pkg::HBS_RUN);
        next_st.setOut   = (next_st.state == hbs_pkg::HBS_RUN) ? speedSetpoint
                                                               : 16'h0000;

        // Without the sequence enable the brake output is held closed (low)
        // whatever the drive does, so the sequencer never acts on it.
        next_st.brakeOut = st.seqEnable ? st.openBrake : 1'b0;
        for (int i = 0; i < TERMS; i++) begin
            next_st.terms[i] = (st.funcSel[i*8 +: 8] == `HBS_FUNC_BRAKE)
                               ? (st.brakeOut ^ st.invSel[i]) : st.invSel[i];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '{state: hbs_pkg::HBS_IDLE, tickCnt: 16'h0000, tick: 1'b0,
                    seqEnable: 1'b0, posMode: 1'b0,
                    openTime: `HBS_RST_OPEN_T, closeSpeed: `HBS_RST_CLOSE_SPD,
                    delayTime: `HBS_RST_DELAY_T, inhibitTime: `HBS_RST_INHIB_T,
                    funcSel: 32'h0000_0000, invSel: 4'h0, ctrlEnPrev: 1'b0,
                    openBrake: 1'b0, brakeOut: 1'b0, terms: 4'h0,
                    setOut: 16'h0000, loopOn: 1'b0, driveOn: 1'b0,
                    statusEn: 1'b0, rdData: 16'h0000};
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state flip-flops.
    assign regRdData          = st.rdData;
    assign speedSetpointOut   = st.setOut;
    assign speedLoopActive    = st.loopOn;
    assign motorDriveEnable   = st.driveOn;
    assign openBrakeInternal  = st.openBrake;
    assign openBrakeStatusBit = st.brakeOut;
    assign outputTerminal     = st.terms;
    assign ctrlEnableStatus   = st.statusEn;

    a_open_start: assert property (@(posedge sys_clk) disable iff (rst)
        loadOpen && pulseEnable |=> st.state == hbs_pkg::HBS_OPENING && st.loopOn
        && st.setOut == 16'h0000) else $error("opening did not start");
    a_setpoint_gate: assert property (@(posedge sys_clk) disable iff (rst)
        st.setOut != 16'h0000 |-> st.state == hbs_pkg::HBS_RUN) else $error("setpoint leaked");
    a_status_enable: assert property (@(posedge sys_clk) disable iff (rst)
        st.statusEn |-> openExpired && st.loopOn) else $error("status before opening time");
    a_pulse_off: assert property (@(posedge sys_clk) disable iff (rst)
        !pulseEnable |=> !st.openBrake && !st.driveOn) else $error("pulse removal ignored");
    a_delay_close: assert property (@(posedge sys_clk) disable iff (rst)
        st.state == hbs_pkg::HBS_INHIBIT && delayExpired && pulseEnable && !ctrlEnable
        |=> !st.openBrake) else $error("delay expiry left brake open");
    a_speed_close: assert property (@(posedge sys_clk) disable iff (rst)
        st.state == hbs_pkg::HBS_INHIBIT && atCloseSpeed && pulseEnable && !ctrlEnable
        |=> !st.openBrake) else $error("close speed left brake open");
    a_inhibit_hold: assert property (@(posedge sys_clk) disable iff (rst)
        st.state == hbs_pkg::HBS_INHIBIT && !inhibitExpired && pulseEnable && !ctrlEnable
        |=> st.loopOn) else $error("loop dropped during inhibit");
    a_seq_disabled: assert property (@(posedge sys_clk) disable iff (rst)
        !st.seqEnable |=> !st.brakeOut) else $error("brake driven while disabled");
endmodule
`default_nettype wire

// file: common/hbs_map.svh
// Constants for the holding brake sequencer: register offsets, fields, resets, timing.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef HBS_MAP_SVH
`define HBS_MAP_SVH

// Register offsets (word index on the plain register port).
`define HBS_ADDR_CTRL      4'h0
`define HBS_ADDR_OPEN_T    4'h1
`define HBS_ADDR_CLOSE_SPD 4'h2
`define HBS_ADDR_DELAY_T   4'h3
`define HBS_ADDR_INHIB_T   4'h4
`define HBS_ADDR_FUNC_SEL  4'h5
`define HBS_ADDR_INV_SEL   4'h6
`define HBS_ADDR_STATUS    4'h7
`define HBS_ADDR_SETPOINT  4'h8

// Control register fields.
`define HBS_CTRL_SEQ_EN    0
`define HBS_CTRL_POS_MODE  1

// Output function code for the holding brake.
`define HBS_FUNC_BRAKE     8'h23

// Reset values.
`define HBS_RST_OPEN_T     16'h0064
`define HBS_RST_CLOSE_SPD  16'h0010
`define HBS_RST_DELAY_T    16'h00C8
`define HBS_RST_INHIB_T    16'h0064

// Timer tick: control-cycle period in ns and clock period in ns.
`define HBS_TICK_NS        125000
`define HBS_CLK_NS         25
`define HBS_TICK_CYC       (`HBS_TICK_NS / `HBS_CLK_NS)

`endif

// file: common/hbs_pkg.sv
// Types for the holding brake sequencer.
// Assumes the map header supplies all numeric constants except the state codes defined here.
`default_nettype none
package hbs_pkg;
    // Sequencer states, Gray coded along open -> run -> close -> inhibit.
    typedef enum logic [2:0] {
        HBS_IDLE    = 3'b000,
        HBS_OPENING = 3'b001,
        HBS_RUN     = 3'b011,
        HBS_CLOSING = 3'b010,
        HBS_INHIBIT = 3'b110
    } hbs_state_t;
endpackage
`default_nettype wire

// file: design/hbs_timer.sv
// Down-counting sequencer timer clocked by the control-cycle tick.
// Assumes load and tick are synchronous to sys_clk; load wins over counting.
`default_nettype none
`include "hbs_map.svh"
module hbs_timer (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Control.
    input  wire logic        load,
    input  wire logic        tick,
    input  wire logic [15:0] preset,
    // Status.
    output logic             expired
);
    typedef struct packed {
        logic [15:0] count;
        logic        done;
    } hbs_tmr_t;

    hbs_tmr_t st;
    hbs_tmr_t next_st;

    // A restart reloads the programmed value even mid-count.
    always_comb begin
        next_st = st;
        if (load) begin
            next_st.count = preset;
            next_st.done  = (preset == 16'h0000);
        end else if (tick && !st.done) begin
            if (st.count <= 16'h0001) begin
                next_st.count = 16'h0000;
                next_st.done  = 1'b1;
            end else begin
                next_st.count = st.count - 16'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '{count: 16'h0000, done: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign expired = st.done;

    // Expiry only ever follows a tick or a zero preset.
    a_timer_expiry: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(st.done) |-> $past(tick) || $past(load)) else $error("timer expired without cause");
endmodule
`default_nettype wire

// file: tb/hbs_brake_relay.sv
// Far-side model: the brake relay on a terminal and a bus master forwarding the status bit.
// Assumes both inputs are sampled on sys_clk; the relay wiring may be active low.
`default_nettype none
module hbs_brake_relay (
    // Clock and reset.
    input  wire logic sys_clk,
    input  wire logic rst,
    // Signals from the drive.
    input  wire logic brakeTerminal,
    input  wire logic brakeStatusBit,
    input  wire logic terminalInverted,
    // Relay states, high while the brake is held open.
    output logic      terminalRelayOpen,
    output logic      masterRelayOpen
);
    timeunit 1ns;
    timeprecision 1ps;

    // The master acts a cycle late, as a real master polls its bus image.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            terminalRelayOpen <= 1'b0;
            masterRelayOpen   <= 1'b0;
        end else begin
            terminalRelayOpen <= brakeTerminal ^ terminalInverted;
            masterRelayOpen   <= brakeStatusBit;
        end
    end
endmodule
`default_nettype wire

// file: tb/hbs_sequencer_test.sv
// Testbench for the holding brake sequencer: register tasks and brake sequences.
// Assumes the map header, package, design files and relay model are compiled first.
`default_nettype none
`include "hbs_map.svh"
module hbs_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = `HBS_TICK_CYC;

    // Stimulus and observed signals.
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [15:0] regRdData;
    logic [3:0]  enables = 4'h0;
    logic [15:0] speedSetpoint = 16'h0123;
    logic [15:0] actualSpeed = 16'h0000;
    logic        invTerm0 = 1'b0;
    logic [15:0] speedSetpointOut;
    logic        speedLoopActive;
    logic        motorDriveEnable;
    logic        openBrakeInternal;
    logic        openBrakeStatusBit;
    logic [3:0]  outputTerminal;
    logic        ctrlEnableStatus;
    logic        termRelay;
    logic        masterRelay;
    int          failCount = 0;
    int          totalChecks = 0;

    // Free-running 40 MHz clock.
    always #12.5 sys_clk = ~sys_clk;

    hbs_sequencer dut (
        .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .ctrlEnableExt(enables[3]), .ctrlEnableInt(enables[2]),
        .pulseEnableExt(enables[1]), .pulseEnableInt(enables[0]),
        .speedSetpoint(speedSetpoint), .actualSpeed(actualSpeed),
        .speedSetpointOut(speedSetpointOut), .speedLoopActive(speedLoopActive),
        .motorDriveEnable(motorDriveEnable), .openBrakeInternal(openBrakeInternal),
        .openBrakeStatusBit(openBrakeStatusBit), .outputTerminal(outputTerminal),
        .ctrlEnableStatus(ctrlEnableStatus));

    hbs_brake_relay relay (
        .sys_clk(sys_clk), .rst(rst), .brakeTerminal(outputTerminal[0]),
        .brakeStatusBit(openBrakeStatusBit), .terminalInverted(invTerm0),
        .terminalRelayOpen(termRelay), .masterRelayOpen(masterRelay));

    // Comparison helper; every call is counted.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            failCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Every driver waits for an edge first, so no signal is assigned twice in one step.
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        check("regRdData", regRdData, exp);
    endtask

    task automatic en(input logic [3:0] v);
        @(posedge sys_clk);
        enables <= v;
    endtask

    // Speed changes land on a rising edge like every other input.
    task automatic spd(input logic [15:0] v);
        @(posedge sys_clk);
        actualSpeed <= v;
    endtask

    // Waits and leaves a nanosecond for the edge's updates to land.
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wrapUp();
        $display("checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Bound on the whole run; the sequences need about fifteen ticks.
    initial begin
        repeat (18 * TICK) @(posedge sys_clk);
        failCount++;
        wrapUp();
    end

    // Main sequence.
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(`HBS_ADDR_CTRL, 16'h0000);
        rd(`HBS_ADDR_OPEN_T, `HBS_RST_OPEN_T);
        rd(`HBS_ADDR_CLOSE_SPD, `HBS_RST_CLOSE_SPD);
        rd(`HBS_ADDR_DELAY_T, `HBS_RST_DELAY_T);
        rd(`HBS_ADDR_INHIB_T, `HBS_RST_INHIB_T);
        rd(4'hF, 16'h0000);
        wr(`HBS_ADDR_OPEN_T, 16'h0002);
        wr(`HBS_ADDR_CLOSE_SPD, 16'h0010);
        wr(`HBS_ADDR_DELAY_T, 16'h0003);
        wr(`HBS_ADDR_INHIB_T, 16'h0004);
        wr(`HBS_ADDR_FUNC_SEL, {8'h00, `HBS_FUNC_BRAKE});
        wr(`HBS_ADDR_INV_SEL, 16'h0002);
        rd(`HBS_ADDR_FUNC_SEL, {8'h00, `HBS_FUNC_BRAKE});
        // Enables present but the sequence switched off.
        en(4'b1111);
        idle(20);
        check("statusBit", openBrakeStatusBit, 1'b0);
        check("terminal", outputTerminal, 4'b0010);
        // Pulses off returns the sequencer to idle without a closing sequence.
        en(4'b1010);
        // One internal condition missing keeps the controller off.
        en(4'b1011);
        wr(`HBS_ADDR_CTRL, 16'h0001);
        idle(20);
        check("loopOn", speedLoopActive, 1'b0);
        en(4'b1111);
        idle(2);
        check("loopOn", speedLoopActive, 1'b1);
        check("openBrake", openBrakeInternal, 1'b1);
        check("setpoint", speedSetpointOut, 16'h0000);
        idle(TICK - 100);
        check("statusEn", ctrlEnableStatus, 1'b0);
        idle(TICK + 200);
        check("statusEn", ctrlEnableStatus, 1'b1);
        check("setpoint", speedSetpointOut, speedSetpoint);
        check("terminal", outputTerminal, 4'b0011);
        check("termRelay", termRelay, 1'b1);
        check("masterRelay", masterRelay, 1'b1);
        rd(`HBS_ADDR_STATUS, {9'h000, hbs_pkg::HBS_RUN, 4'hF});
        rd(`HBS_ADDR_SETPOINT, 16'h0123);
        // Drop the controller enable while still fast, then cross the threshold.
        spd(16'h0064);
        en(4'b0111);
        idle(3);
        check("setpoint", speedSetpointOut, 16'h0000);
        check("loopOn", speedLoopActive, 1'b1);
        check("openBrake", openBrakeInternal, 1'b1);
        spd(16'h0010);
        idle(3);
        check("openBrake", openBrakeInternal, 1'b0);
        idle(3 * TICK - 200);
        check("loopOn", speedLoopActive, 1'b1);
        idle(TICK + 400);
        check("loopOn", speedLoopActive, 1'b0);
        // Positioning mode, re-enable in mid-close, then timeout closing.
        wr(`HBS_ADDR_CTRL, 16'h0003);
        rd(`HBS_ADDR_CTRL, 16'h0003);
        spd(16'h0064);
        en(4'b1111);
        idle(2 * TICK + 200);
        check("statusEn", ctrlEnableStatus, 1'b1);
        en(4'b0111);
        idle(100);
        en(4'b1111);
        idle(3);
        check("openBrake", openBrakeInternal, 1'b1);
        check("statusEn", ctrlEnableStatus, 1'b0);
        idle(TICK - 100);
        check("statusEn", ctrlEnableStatus, 1'b0);
        idle(TICK + 300);
        check("statusEn", ctrlEnableStatus, 1'b1);
        en(4'b0111);
        idle(2 * TICK - 200);
        check("openBrake", openBrakeInternal, 1'b1);
        idle(TICK + 400);
        check("openBrake", openBrakeInternal, 1'b0);
        // Pulse removal from the running state.
        en(4'b1111);
        idle(2 * TICK + 200);
        en(4'b1110);
        idle(2);
        check("driveOn", motorDriveEnable, 1'b0);
        check("openBrake", openBrakeInternal, 1'b0);
        check("loopOn", speedLoopActive, 1'b0);
        idle(5);
        check("statusBit", openBrakeStatusBit, 1'b0);
        check("masterRelay", masterRelay, 1'b0);
        // Invert terminal zero; the relay wiring follows the inversion.
        wr(`HBS_ADDR_INV_SEL, 16'h0003);
        invTerm0 <= 1'b1;
        idle(5);
        check("terminal", outputTerminal, 4'b0011);
        check("termRelay", termRelay, 1'b0);
        wrapUp();
    end
endmodule
`default_nettype wire
